// >>> gpio_dir_and_level_regs.sv
// Overview of operation
// - A one written to drive-enable set makes that pin an output.
// - Zero bits written to any set, clear or toggle alias change nothing.
// - A one written to drive-enable toggle reverses that pin's direction.
// - Drive-enable and its three aliases read and write one shared storage.
// - Output level and its three aliases read and write one shared storage.
// - Groups of up to 32 pins, each register set 0x80 above the last.
// - An output pin is driven low for level zero, high for one.
// - A pulled input pulls down for level zero, up for one.
// - A one written to level clear clears that level bit.
// - Clearing the level of a pulled input selects pull-down.
// - One alias write updates many pins at once, others untouched.
// - Drive-enable zero makes a pin input, one makes it output.
// - A one written to drive-enable clear returns that pin to input.
// - A one written to level set sets that level bit.
// - A one written to level toggle inverts that level bit.
`timescale 1ns/1ns
`default_nettype none

module gpio_dir_and_level_regs #(
    parameter int NUM_GROUPS = gpio_dir_and_level_pkg::DEF_GROUPS,
    parameter int PINS_PER_GROUP = gpio_dir_and_level_pkg::MAX_PINS,
    parameter int ADDR_W = gpio_dir_and_level_pkg::DEF_ADDR_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [gpio_dir_and_level_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [gpio_dir_and_level_pkg::DATA_W-1:0] o_rd_data,
    output logic o_wr_refused,
    // Write guard lock level
    input wire logic i_write_lock,
    // Pull resistor enables per group, from pin configuration
    input wire logic [PINS_PER_GROUP-1:0] i_pull_resistor_enable [NUM_GROUPS],
    // Pad control per group
    output gpio_dir_and_level_pkg::pad_ctrl_t o_pads [NUM_GROUPS]
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int GRP_W = ADDR_W - gpio_dir_and_level_pkg::GROUP_SHIFT;

    if (PINS_PER_GROUP < 1 || PINS_PER_GROUP > gpio_dir_and_level_pkg::MAX_PINS) begin : g_bad_pins
        $error("PINS_PER_GROUP must be 1 to 32");
    end
    if (NUM_GROUPS < 1) begin : g_bad_groups
        $error("NUM_GROUPS must be at least 1");
    end
    if (GRP_W < 1 || (2 ** GRP_W) < NUM_GROUPS) begin : g_bad_addr
        $error("ADDR_W too narrow for NUM_GROUPS");
    end
    if (gpio_dir_and_level_pkg::DATA_W < PINS_PER_GROUP) begin : g_bad_data
        $error("Write data narrower than PINS_PER_GROUP");
    end

    // ------------------------------------------------------------
    // Shared address decode
    // ------------------------------------------------------------
    logic [gpio_dir_and_level_pkg::OFFS_W-1:0] offs;
    logic [GRP_W-1:0] grp_sel;
    logic wr_allowed;
    logic [PINS_PER_GROUP-1:0] wr_bits;
    logic [gpio_dir_and_level_pkg::DATA_W-1:0] grp_rd_word [NUM_GROUPS];
    logic [gpio_dir_and_level_pkg::DATA_W-1:0] next_rd_data;
    logic next_wr_refused;

    // Offset inside a group, group index above it
    assign offs = i_addr[gpio_dir_and_level_pkg::OFFS_W-1:0];
    assign grp_sel = i_addr[ADDR_W-1:gpio_dir_and_level_pkg::GROUP_SHIFT];
    assign wr_bits = i_wr_data[PINS_PER_GROUP-1:0];

    // ------------------------------------------------------------
    // Write qualification
    // ------------------------------------------------------------
    // lock gate
    assign wr_allowed = i_wr_en && !i_write_lock;

    // write dropped by the lock, reported a cycle later
    assign next_wr_refused = i_wr_en && i_write_lock;

    // ------------------------------------------------------------
    // Per-group storage and pad control
    // ------------------------------------------------------------
    // group stride
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
        logic grp_hit;
        logic [PINS_PER_GROUP-1:0] drive_enable;
        logic [PINS_PER_GROUP-1:0] level_value;
        logic [PINS_PER_GROUP-1:0] next_drive_enable;
        logic [PINS_PER_GROUP-1:0] next_level_value;
        logic [PINS_PER_GROUP-1:0] pull_on;
        logic [PINS_PER_GROUP-1:0] pull_up;
        logic grp_wr;
        logic [PINS_PER_GROUP-1:0] pull_enable;
        logic [gpio_dir_and_level_pkg::MAX_PINS-1:0] drive_wide;
        logic [gpio_dir_and_level_pkg::MAX_PINS-1:0] level_wide;
        logic [gpio_dir_and_level_pkg::MAX_PINS-1:0] pull_on_wide;
        logic [gpio_dir_and_level_pkg::MAX_PINS-1:0] pull_up_wide;

        // --------------------------------------------------------
        // Group select
        // --------------------------------------------------------
        // Group selected by the upper address bits
        assign grp_hit = (grp_sel == GRP_W'(g));

        // Accepted write aimed at this group
        assign grp_wr = wr_allowed && grp_hit;

        // Pull enables of this group's pins
        assign pull_enable = i_pull_resistor_enable[g];

        // --------------------------------------------------------
        // Direction update from the plain register or its aliases
        // --------------------------------------------------------
        always_comb begin
            next_drive_enable = drive_enable;
            if (grp_wr) begin
                case (offs)
                    gpio_dir_and_level_pkg::OFS_DRIVE_ENABLE: begin
                        next_drive_enable = wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_DRIVE_CLEAR: begin
                        next_drive_enable = drive_enable & ~wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_DRIVE_SET: begin
                        next_drive_enable = drive_enable | wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_DRIVE_TOGGLE: begin
                        next_drive_enable = drive_enable ^ wr_bits;
                    end
                    default: begin
                        next_drive_enable = drive_enable;
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // Level update from the plain register or its aliases
        // --------------------------------------------------------
        always_comb begin
            next_level_value = level_value;
            if (grp_wr) begin
                case (offs)
                    gpio_dir_and_level_pkg::OFS_LEVEL_VALUE: begin
                        next_level_value = wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_LEVEL_CLEAR: begin
                        next_level_value = level_value & ~wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_LEVEL_SET: begin
                        next_level_value = level_value | wr_bits;
                    end
                    gpio_dir_and_level_pkg::OFS_LEVEL_TOGGLE: begin
                        next_level_value = level_value ^ wr_bits;
                    end
                    default: begin
                        next_level_value = level_value;
                    end
                endcase
            end
        end

        // --------------------------------------------------------
        // Direction storage
        // --------------------------------------------------------
        // masked update
        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
                drive_enable <= gpio_dir_and_level_pkg::RST_DRIVE_ENABLE[PINS_PER_GROUP-1:0];
            end else begin
                drive_enable <= next_drive_enable;
            end
        end

        // --------------------------------------------------------
        // Level storage
        // --------------------------------------------------------
        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
                level_value <= gpio_dir_and_level_pkg::RST_LEVEL_VALUE[PINS_PER_GROUP-1:0];
            end else begin
                level_value <= next_level_value;
            end
        end

        // --------------------------------------------------------
        // Pull control, follows direction and level in the same cycle
        // --------------------------------------------------------
        always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
                pull_on <= '0;
                pull_up <= '0;
            end else begin
                pull_on <= ~next_drive_enable & pull_enable;
                pull_up <= ~next_drive_enable & pull_enable & next_level_value;
            end
        end

        // --------------------------------------------------------
        // Pad outputs, unused upper pins held at zero
        // --------------------------------------------------------
        // direction to pad
        assign drive_wide = gpio_dir_and_level_pkg::MAX_PINS'(drive_enable);
        assign level_wide = gpio_dir_and_level_pkg::MAX_PINS'(level_value);
        // Pull fields widened the same way
        assign pull_on_wide = gpio_dir_and_level_pkg::MAX_PINS'(pull_on);
        assign pull_up_wide = gpio_dir_and_level_pkg::MAX_PINS'(pull_up);

        // Whole pad word in one assignment, one driver per group
        assign o_pads[g] = '{
            drive_en: drive_wide,
            level: level_wide,
            pull_on: pull_on_wide,
            pull_up: pull_up_wide
        };

        // --------------------------------------------------------
        // Read word of this group, zero when another group is addressed
        // --------------------------------------------------------
        always_comb begin
            grp_rd_word[g] = gpio_dir_and_level_pkg::READ_UNMAPPED;
            if (grp_hit) begin
                case (offs)
                    gpio_dir_and_level_pkg::OFS_DRIVE_ENABLE,
                    gpio_dir_and_level_pkg::OFS_DRIVE_CLEAR,
                    gpio_dir_and_level_pkg::OFS_DRIVE_SET,
                    gpio_dir_and_level_pkg::OFS_DRIVE_TOGGLE: begin
                        grp_rd_word[g] = gpio_dir_and_level_pkg::DATA_W'(drive_enable);
                    end
                    gpio_dir_and_level_pkg::OFS_LEVEL_VALUE,
                    gpio_dir_and_level_pkg::OFS_LEVEL_CLEAR,
                    gpio_dir_and_level_pkg::OFS_LEVEL_SET,
                    gpio_dir_and_level_pkg::OFS_LEVEL_TOGGLE: begin
                        grp_rd_word[g] = gpio_dir_and_level_pkg::DATA_W'(level_value);
                    end
                    default: begin
                        grp_rd_word[g] = gpio_dir_and_level_pkg::READ_UNMAPPED;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and refused write flag
    // ------------------------------------------------------------
    // Merge of group read words, at most one is non-zero
    always_comb begin
        next_rd_data = gpio_dir_and_level_pkg::READ_UNMAPPED;
        if (i_rd_en) begin
            for (int k = 0; k < NUM_GROUPS; k++) begin
                next_rd_data = next_rd_data | grp_rd_word[k];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rd_data <= gpio_dir_and_level_pkg::READ_UNMAPPED;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Refused write flag
    // ------------------------------------------------------------
    // One-cycle pulse for a write dropped by the lock
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_wr_refused <= 1'b0;
        end else begin
            o_wr_refused <= next_wr_refused;
        end
    end

endmodule : gpio_dir_and_level_regs

`default_nettype wire

// >>> gpio_dir_and_level_pkg.sv
package gpio_dir_and_level_pkg;

    // ------------------------------------------------------------
    // Bus and group geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int MAX_PINS = 32;
    localparam int DEF_GROUPS = 2;
    localparam int DEF_ADDR_W = 8;
    localparam int GROUP_SHIFT = 7; // 0x80 bytes per group
    localparam int OFFS_W = GROUP_SHIFT;

    // ------------------------------------------------------------
    // Register offsets inside one group
    // ------------------------------------------------------------
    localparam logic [OFFS_W-1:0] OFS_DRIVE_ENABLE = 7'h00;
    localparam logic [OFFS_W-1:0] OFS_DRIVE_CLEAR = 7'h04;
    localparam logic [OFFS_W-1:0] OFS_DRIVE_SET = 7'h08;
    localparam logic [OFFS_W-1:0] OFS_DRIVE_TOGGLE = 7'h0c;
    localparam logic [OFFS_W-1:0] OFS_LEVEL_VALUE = 7'h10;
    localparam logic [OFFS_W-1:0] OFS_LEVEL_CLEAR = 7'h14;
    localparam logic [OFFS_W-1:0] OFS_LEVEL_SET = 7'h18;
    localparam logic [OFFS_W-1:0] OFS_LEVEL_TOGGLE = 7'h1c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_DRIVE_ENABLE = 32'h00000000;
    localparam logic [DATA_W-1:0] RST_LEVEL_VALUE = 32'h00000000;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h00000000;

    // ------------------------------------------------------------
    // Pad control carried to the pin drivers of one group
    // ------------------------------------------------------------
    typedef struct packed {
        logic [MAX_PINS-1:0] drive_en;
        logic [MAX_PINS-1:0] level;
        logic [MAX_PINS-1:0] pull_on;
        logic [MAX_PINS-1:0] pull_up;
    } pad_ctrl_t;

endpackage : gpio_dir_and_level_pkg

// >>> gpio_dir_and_level_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_dir_and_level_regs_chk #(
    parameter int NUM_GROUPS = 2,
    parameter int PINS_PER_GROUP = 32,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [31:0] o_rd_data,
    input wire logic o_wr_refused,
    // Lock, pulls and pads
    input wire logic i_write_lock,
    input wire logic [PINS_PER_GROUP-1:0] i_pull_resistor_enable [NUM_GROUPS],
    input wire gpio_dir_and_level_pkg::pad_ctrl_t o_pads [NUM_GROUPS]
);
    // Group views and accepted write
    logic [31:0] d0, l0, d1, pe0;
    logic w;
    assign d0 = o_pads[0].drive_en;
    assign l0 = o_pads[0].level;
    assign d1 = o_pads[1].drive_en;
    assign pe0 = 32'(i_pull_resistor_enable[0]);
    assign w = i_wr_en && !i_write_lock;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_DIR_SET: assert property (w && i_addr == 8'h08 |=> d0 == ($past(d0) | $past(i_wr_data)))
        else $error("dir set");
    AST_DIR_CLR: assert property (w && i_addr == 8'h04 |=> d0 == ($past(d0) & ~$past(i_wr_data)))
        else $error("dir clear");
    AST_DIR_TGL: assert property (w && i_addr == 8'h0c |=> d0 == ($past(d0) ^ $past(i_wr_data)))
        else $error("dir toggle");
    AST_LVL_CLR: assert property (w && i_addr == 8'h14 |=> l0 == ($past(l0) & ~$past(i_wr_data)))
        else $error("level clear");
    AST_LVL_TGL: assert property (w && i_addr == 8'h1c |=> l0 == ($past(l0) ^ $past(i_wr_data)))
        else $error("level toggle");
    AST_GRP_SET: assert property (w && i_addr == 8'h88 |=> d1 == ($past(d1) | $past(i_wr_data)))
        else $error("group one set");
    AST_LOCK: assert property (i_wr_en && i_write_lock |=> o_wr_refused && $stable(d0) && $stable(l0))
        else $error("locked write");
    AST_PULL_UP: assert property ($past(i_rst_n) |-> o_pads[0].pull_up == (~d0 & $past(pe0) & l0))
        else $error("pull up");
    AST_RD_TGL: assert property (i_rd_en && i_addr == 8'h0c |=> o_rd_data == $past(d0))
        else $error("toggle readback");
    // read data only after a strobe
    AST_RD_IDLE: assert property (!i_rd_en |=> o_rd_data == 32'h00000000)
        else $error("read data without strobe");
    // no refusal without a locked write
    AST_NO_REFUSE: assert property (!(i_wr_en && i_write_lock) |=> !o_wr_refused)
        else $error("spurious refusal");
    AST_LVL_SET: assert property (w && i_addr == 8'h18 |=> l0 == ($past(l0) | $past(i_wr_data)))
        else $error("level set");
    AST_PULL_ON: assert property ($past(i_rst_n) |-> o_pads[0].pull_on == (~d0 & $past(pe0)))
        else $error("pull on");
endmodule : gpio_dir_and_level_regs_chk
bind gpio_dir_and_level_regs gpio_dir_and_level_regs_chk #(.NUM_GROUPS(NUM_GROUPS),
    .PINS_PER_GROUP(PINS_PER_GROUP), .ADDR_W(ADDR_W)) chk_i (.i_sys_clk, .i_rst_n, .i_addr,
    .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_wr_refused, .i_write_lock,
    .i_pull_resistor_enable, .o_pads);
`default_nettype wire

// >>> gpio_dir_and_level_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module gpio_dir_and_level_regs_tb_top;
    // ------------------------------------------------------------
    // Signals and reference storage
    // ------------------------------------------------------------
    logic i_sys_clk, i_rst_n, i_wr_en, i_rd_en, i_write_lock, o_wr_refused;
    logic [7:0] i_addr;
    logic [31:0] i_wr_data, o_rd_data;
    logic [31:0] i_pull_resistor_enable [2];
    gpio_dir_and_level_pkg::pad_ctrl_t o_pads [2];
    logic [31:0] md [2], ml [2];
    int mismatches, tests_run;

    gpio_dir_and_level_regs gpio_dir_and_level_regs_i (.i_sys_clk, .i_rst_n, .i_addr, .i_wr_data,
        .i_wr_en, .i_rd_en, .o_rd_data, .o_wr_refused, .i_write_lock, .i_pull_resistor_enable, .o_pads);

    // Clock, 8 ns
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        d = a[4] ? ml[a[7]] : md[a[7]];
        case (a[3:2])
            2'h0: d = v;
            2'h1: d = d & ~v;
            2'h2: d = d | v;
            default: d = d ^ v;
        endcase
        if (!i_write_lock && a[6:5] == 2'h0 && a[1:0] == 2'h0) begin
            if (a[4]) ml[a[7]] = d;
            else md[a[7]] = d;
        end
        i_wr_en <= 1'b1;
        i_rd_en <= 1'b0;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_wr_en <= 1'b0;
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_rd_data, exp);
        chk({31'h0, o_wr_refused}, 32'h00000000);
        @(posedge i_sys_clk);
    endtask : rd

    // Every alias and every pad field of both groups
    task automatic chkall();
        for (int g = 0; g < 2; g++) begin
            for (int o = 0; o < 8; o++) begin
                rd({g[0], 2'h0, o[2:0], 2'h0}, o[2] ? ml[g] : md[g]);
            end
            chk(o_pads[g].drive_en, md[g]);
            chk(o_pads[g].level, ml[g]);
            chk(o_pads[g].pull_on, ~md[g] & i_pull_resistor_enable[g]);
            chk(o_pads[g].pull_up, ~md[g] & i_pull_resistor_enable[g] & ml[g]);
        end
    endtask : chkall

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst_n = 1'b0;
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        i_write_lock = 1'b0;
        i_addr = 8'h00;
        i_wr_data = 32'h00000000;
        i_pull_resistor_enable[0] = 32'h0f0f0f0f;
        i_pull_resistor_enable[1] = 32'hffff0000;
        md = '{32'h00000000, 32'h00000000};
        ml = '{32'h00000000, 32'h00000000};
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        chkall();
        // Back-to-back alias writes, both groups
        wr(8'h00, 32'h000000f0);
        wr(8'h08, 32'h0000000f);
        wr(8'h04, 32'h00000003);
        wr(8'h0c, 32'h80000101);
        wr(8'h10, 32'h000000a5);
        wr(8'h18, 32'h00000300);
        chkall();
        wr(8'h14, 32'h00010205);
        wr(8'h1c, 32'hffff0000);
        wr(8'h88, 32'h12345678);
        wr(8'h94, 32'h00000000);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h00000000);
        chkall();
        // Locked write refused
        i_write_lock <= 1'b1;
        @(posedge i_sys_clk);
        wr(8'h0c, 32'hffffffff);
        i_wr_en <= 1'b0;
        i_write_lock <= 1'b0;
        @(negedge i_sys_clk);
        chk({31'h0, o_wr_refused}, 32'h00000001);
        @(posedge i_sys_clk);
        chkall();
        // Reset in mid-run
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        md = '{32'h00000000, 32'h00000000};
        ml = '{32'h00000000, 32'h00000000};
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        chkall();
        finish_test();
    end
endmodule : gpio_dir_and_level_regs_tb_top
`default_nettype wire
